/* design/lsfr_decode.v */
// Reaction code decoder for the limit switch fault reaction block
`timescale 1ns/100ps
`include "lsfr_defs.vh"

module lsfr_decode
(
    input wire [15:0] code,
    output reg record_pos,
    output reg power_off,
    output reg [1:0] ramp_sel,
    output reg [1:0] end_state
);
    always @*
    begin
        record_pos = 1'b0;
        power_off = 1'b0;
        ramp_sel = `LSFR_RAMP_NONE;
        end_state = `LSFR_DS_RUN;
        case (code)
            `LSFR_CODE_DISCARD:
            begin
                record_pos = 1'b0;
            end
            `LSFR_CODE_COAST:
            begin
                power_off = 1'b1;
                end_state = `LSFR_DS_DISABLED;
            end
            `LSFR_CODE_SLOW_DIS:
            begin
                ramp_sel = `LSFR_RAMP_SLOW;
                end_state = `LSFR_DS_DISABLED;
            end
            `LSFR_CODE_QUICK_DIS:
            begin
                ramp_sel = `LSFR_RAMP_QUICK;
                end_state = `LSFR_DS_DISABLED;
            end
            `LSFR_CODE_SLOW_QSA:
            begin
                ramp_sel = `LSFR_RAMP_SLOW;
                end_state = `LSFR_DS_QSA;
            end
            `LSFR_CODE_QUICK_QSA:
            begin
                ramp_sel = `LSFR_RAMP_QUICK;
                end_state = `LSFR_DS_QSA;
            end
            default:
            begin
                // Code -1 and every unlisted code
                record_pos = 1'b1;
            end
        endcase
    end
endmodule // lsfr_decode

/* design/lsfr_defs.vh */
// Constants for the limit switch fault reaction block
// Summary of operation
// - On limit switch pass, set status warning bit 7, then run stored reaction.
// - Code -1 (reset value): no stop, record the limit switch position.
// - Code -2: no stop, discard the limit switch position.
// - Code 0: disable driver at once, motor coasts, go switch-on-disabled.
// - Code 1 slow-down ramp, code 2 quick-stop ramp, then switch-on-disabled.
// - Codes 5 and 6 brake, enter quick-stop-active, stay energized, may re-enable.
// - Reaction code is signed 16-bit read/write, reset FFFF, application save category.
// - Non-volatile memory size read-only 32-bit, zero when none fitted.
// - One reserved 32-bit read/write hardware configuration word, no effect.
`ifndef LSFR_DEFS_VH
`define LSFR_DEFS_VH

// =====================================================================
// Dictionary addressing
`define LSFR_IDX_REACTION 16'h3701
`define LSFR_IDX_HW_INFO 16'h4012
`define LSFR_IDX_HW_CFG 16'h4013
`define LSFR_SUB_COUNT 8'h00
`define LSFR_SUB_FIRST 8'h01

// =====================================================================
// Reset and fixed values
`define LSFR_REACTION_RST 16'hffff
`define LSFR_ENTRY_COUNT 8'h01
`define LSFR_HW_CFG_RST 32'h0000_0000
`define LSFR_ZERO32 32'h0000_0000
`define LSFR_ZERO16 16'h0000
`define LSFR_WARN_BIT 7

// =====================================================================
// Reaction codes
`define LSFR_CODE_DISCARD 16'hfffe
`define LSFR_CODE_NONE 16'hffff
`define LSFR_CODE_COAST 16'h0000
`define LSFR_CODE_SLOW_DIS 16'h0001
`define LSFR_CODE_QUICK_DIS 16'h0002
`define LSFR_CODE_SLOW_QSA 16'h0005
`define LSFR_CODE_QUICK_QSA 16'h0006

// =====================================================================
// Ramp and drive-state encodings
`define LSFR_RAMP_NONE 2'h0
`define LSFR_RAMP_SLOW 2'h1
`define LSFR_RAMP_QUICK 2'h2
`define LSFR_DS_RUN 2'h0
`define LSFR_DS_DISABLED 2'h1
`define LSFR_DS_QSA 2'h2

`endif

/* design/lsfr_top.v */
// Limit switch fault reaction: dictionary entries and reaction sequencer
`timescale 1ns/100ps
`include "lsfr_defs.vh"

module lsfr_top
(
    input wire clk_sys,
    input wire reset_n,
    // Dictionary access from the fieldbus side
    input wire dict_wr,
    input wire dict_rd,
    input wire [15:0] dict_index,
    input wire [7:0] dict_subindex,
    input wire [31:0] dict_wdata,
    output reg [31:0] dict_rdata_q,
    output reg dict_ack_q,
    output reg dict_err_q,
    // Drive side
    input wire limit_hit,
    input wire [31:0] axis_position,
    input wire [31:0] nvm_size,
    input wire ramp_done,
    input wire reenable_req,
    output reg status_warning_q,
    output reg power_off_q,
    output reg [1:0] ramp_sel_q,
    output reg [1:0] drive_state_q,
    output reg limit_pos_valid_q,
    output reg [31:0] limit_pos_q
);
    // =====================================================================
    // Sequencer states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_BRAKE = 3'b010;
    localparam [2:0] ST_HOLD = 3'b100;

    reg [15:0] reaction_q;
    reg [31:0] hw_cfg_q;
    reg [2:0] state_q;
    reg [1:0] end_state_q;
    wire dec_record;
    wire dec_power_off;
    wire [1:0] dec_ramp;
    wire [1:0] dec_end;
    wire hit_reaction;
    wire hit_info;
    wire hit_cfg;
    wire sub_count;
    wire sub_first;

    // =====================================================================
    // Reaction decode
    lsfr_decode u_decode
    (
        .code(reaction_q),
        .record_pos(dec_record),
        .power_off(dec_power_off),
        .ramp_sel(dec_ramp),
        .end_state(dec_end)
    );

    // =====================================================================
    // Dictionary access
    assign hit_reaction = (dict_index == `LSFR_IDX_REACTION);
    assign hit_info = (dict_index == `LSFR_IDX_HW_INFO);
    assign hit_cfg = (dict_index == `LSFR_IDX_HW_CFG);
    assign sub_count = (dict_subindex == `LSFR_SUB_COUNT);
    assign sub_first = (dict_subindex == `LSFR_SUB_FIRST);

    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            reaction_q <= `LSFR_REACTION_RST;
            hw_cfg_q <= `LSFR_HW_CFG_RST;
            dict_rdata_q <= `LSFR_ZERO32;
            dict_ack_q <= 1'b0;
            dict_err_q <= 1'b0;
        end
        else
        begin
            dict_ack_q <= dict_wr | dict_rd;
            dict_err_q <= 1'b0;
            dict_rdata_q <= `LSFR_ZERO32;
            if (dict_wr)
            begin
                // Only the reaction code and the configuration word are writable; counts and the memory size are read-only
                if (hit_reaction && sub_count)
                    reaction_q <= dict_wdata[15:0];
                else if (hit_cfg && sub_first)
                    hw_cfg_q <= dict_wdata;
                else
                    dict_err_q <= 1'b1;
            end
            else if (dict_rd)
            begin
                if (hit_reaction && sub_count)
                    dict_rdata_q <= {{16{reaction_q[15]}}, reaction_q};
                else if ((hit_info || hit_cfg) && sub_count)
                    dict_rdata_q <= {24'h00_0000, `LSFR_ENTRY_COUNT};
                else if (hit_info && sub_first)
                    dict_rdata_q <= nvm_size;
                else if (hit_cfg && sub_first)
                    dict_rdata_q <= hw_cfg_q;
                else
                    dict_err_q <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Reaction sequencer
    // The code is sampled at the hit, so a later rewrite cannot change a reaction in progress
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            end_state_q <= `LSFR_DS_RUN;
            status_warning_q <= 1'b0;
            power_off_q <= 1'b0;
            ramp_sel_q <= `LSFR_RAMP_NONE;
            drive_state_q <= `LSFR_DS_RUN;
            limit_pos_valid_q <= 1'b0;
            limit_pos_q <= `LSFR_ZERO32;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (limit_hit)
                    begin
                        status_warning_q <= 1'b1;
                        limit_pos_valid_q <= dec_record;
                        limit_pos_q <= dec_record ? axis_position : `LSFR_ZERO32;
                        if (dec_power_off)
                        begin
                            power_off_q <= 1'b1;
                            drive_state_q <= `LSFR_DS_DISABLED;
                            state_q <= ST_HOLD;
                        end
                        else if (dec_ramp != `LSFR_RAMP_NONE)
                        begin
                            ramp_sel_q <= dec_ramp;
                            end_state_q <= dec_end;
                            state_q <= ST_BRAKE;
                        end
                    end
                end
                ST_BRAKE:
                begin
                    if (ramp_done)
                    begin
                        ramp_sel_q <= `LSFR_RAMP_NONE;
                        drive_state_q <= end_state_q;
                        // Disabled end cuts power; quick-stop-active keeps the motor energized
                        power_off_q <= (end_state_q == `LSFR_DS_DISABLED);
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    // Leaving the fault state is a master decision; it also clears the warning
                    if (reenable_req)
                    begin
                        power_off_q <= 1'b0;
                        drive_state_q <= `LSFR_DS_RUN;
                        status_warning_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // lsfr_top

/* sim/lsfr_asserts.sv */
// Concurrent checks on the limit switch fault reaction ports
`timescale 1ns/100ps
module lsfr_asserts
(
    input wire logic clk_sys, reset_n, dict_wr, dict_rd, dict_ack_q, dict_err_q, limit_hit, ramp_done,
    input wire logic reenable_req, status_warning_q, power_off_q, limit_pos_valid_q,
    input wire logic [15:0] dict_index,
    input wire logic [7:0] dict_subindex,
    input wire logic [31:0] dict_wdata, dict_rdata_q, axis_position, nvm_size, limit_pos_q,
    input wire logic [1:0] ramp_sel_q, drive_state_q
);
    logic [15:0] code_q;
    logic stop_c;
    // =====
    // Shadow of the stored code, rebuilt from write traffic
    always @(posedge clk_sys)
        if (!reset_n)
            code_q <= 16'hffff;
        else if (dict_wr && dict_index == 16'h3701 && dict_subindex == 8'h00)
            code_q <= dict_wdata[15:0];
    assign stop_c = code_q inside {16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_hit; limit_hit && drive_state_q == 2'h0 && ramp_sel_q == 2'h0; endsequence
    sequence s_stop; ramp_sel_q != 2'h0 && ramp_done; endsequence
    // =====
    // Properties
    property p_warn; s_hit |=> status_warning_q; endproperty
    property p_keep; status_warning_q && !reenable_req |=> status_warning_q; endproperty
    property p_nostop; (s_hit and !stop_c) |=> drive_state_q == 2'h0 && ramp_sel_q == 2'h0 && !power_off_q; endproperty
    property p_rec; (s_hit and code_q == 16'hffff) |=> limit_pos_valid_q && limit_pos_q == $past(axis_position);
    endproperty
    property p_disc; (s_hit and code_q == 16'hfffe) |=> !limit_pos_valid_q; endproperty
    property p_coast; (s_hit and code_q == 16'h0000) |=> power_off_q && drive_state_q == 2'h1; endproperty
    property p_rsel; (s_hit and (stop_c && code_q != 16'h0000)) |=> ramp_sel_q == code_q[1:0] && !power_off_q;
    endproperty
    property p_end; s_stop |=> ramp_sel_q == 2'h0 && drive_state_q == (code_q[2] ? 2'h2 : 2'h1); endproperty
    property p_reen; drive_state_q == 2'h2 && reenable_req |=> drive_state_q == 2'h0 && !status_warning_q; endproperty
    property p_code; dict_rd && !dict_wr && dict_index == 16'h3701 && dict_subindex == 8'h00
        |=> dict_rdata_q == {{16{code_q[15]}}, code_q}; endproperty
    property p_nvm; dict_rd && !dict_wr && dict_index == 16'h4012 && dict_subindex == 8'h01
        |=> dict_rdata_q == $past(nvm_size); endproperty
    property p_ro; dict_wr && dict_index == 16'h4012 && dict_subindex == 8'h01 |=> dict_ack_q && dict_err_q; endproperty
    a_warn: assert property (p_warn) else $error("warning not raised");
    a_keep: assert property (p_keep) else $error("warning dropped");
    a_nostop: assert property (p_nostop) else $error("stop on no-stop code");
    a_rec: assert property (p_rec) else $error("position not recorded");
    a_disc: assert property (p_disc) else $error("position not discarded");
    a_coast: assert property (p_coast) else $error("coast reaction wrong");
    a_rsel: assert property (p_rsel) else $error("ramp select wrong");
    a_end: assert property (p_end) else $error("end state wrong");
    a_reen: assert property (p_reen) else $error("re-enable failed");
    a_code: assert property (p_code) else $error("code readback wrong");
    a_nvm: assert property (p_nvm) else $error("memory size wrong");
    a_ro: assert property (p_ro) else $error("read-only write accepted");
endmodule // lsfr_asserts
bind lsfr_top lsfr_asserts u_chk (.*);

/* sim/lsfr_master.sv */
// Fieldbus master model that issues dictionary reads and writes
`timescale 1ns/100ps
module lsfr_master
(
    input wire logic clk_sys, dict_ack_q, dict_err_q,
    input wire logic [31:0] dict_rdata_q,
    output logic dict_wr, dict_rd,
    output logic [15:0] dict_index,
    output logic [7:0] dict_subindex,
    output logic [31:0] dict_wdata
);
    initial {dict_wr, dict_rd, dict_index, dict_subindex, dict_wdata} = '0;
    // =====
    // Transfer
    // One pulse per request; lines are scrambled afterwards so a stale address never looks valid
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
        output logic [31:0] q, output logic e, output logic a);
        @(posedge clk_sys);
        {dict_wr, dict_rd, dict_index, dict_subindex, dict_wdata} <= {w, !w, i, s, d};
        @(posedge clk_sys);
        {dict_wr, dict_rd, dict_index, dict_subindex, dict_wdata} <= {2'h0, ~i, ~s, ~d};
        @(posedge clk_sys);
        {a, e, q} = {dict_ack_q, dict_err_q, dict_rdata_q};
    endtask
endmodule // lsfr_master

/* sim/lsfr_top_tb.sv */
// Self-checking testbench for the limit switch fault reaction block
`timescale 1ns/100ps
module lsfr_top_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, limit_hit = 1'b0, ramp_done = 1'b0, reenable_req = 1'b0;
    logic dict_wr, dict_rd, dict_ack_q, dict_err_q, status_warning_q, power_off_q, limit_pos_valid_q, e, a;
    logic [15:0] dict_index;
    logic [7:0] dict_subindex;
    logic [31:0] axis_position = 32'h0000_0000, nvm_size = 32'h0000_0000, dict_wdata, dict_rdata_q, limit_pos_q, q;
    logic [1:0] ramp_sel_q, drive_state_q, ramp;
    int err_count = 0, total_checks = 0, cyc = 0, c;
    int codes[8] = '{0, 1, 2, 5, 6, -1, -2, 3};
    lsfr_top u_dut (.*);
    lsfr_master u_mst (.*);
    always #50 clk_sys = ~clk_sys;
    // Generous ceiling; the whole run needs fewer than 200 cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            err_count++;
            test_done();
        end
    end
    // =====
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xf(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ee);
        u_mst.xfer(w, i, s, d, q, e, a);
        chk({a, e}, {1'b1, ee});
        if (!w)
            chk(q, d);
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        axis_position <= $urandom;
        {limit_hit, ramp_done, reenable_req} <= {k == 0, k == 1, k == 2};
        @(posedge clk_sys);
        {limit_hit, ramp_done, reenable_req} <= 3'h0;
        @(posedge clk_sys);
    endtask
    task automatic test_done();
        $display("TB: checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // =====
    // Main sequence
    initial
    begin
        void'($urandom(82119));
        nvm_size <= $urandom;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        xf(0, 16'h3701, 8'h00, 32'hffff_ffff, 0);
        xf(0, 16'h4012, 8'h00, 32'h0000_0001, 0);
        xf(0, 16'h4012, 8'h01, nvm_size, 0);
        xf(1, 16'h4012, 8'h01, 32'h0000_0005, 1);
        xf(0, 16'h4012, 8'h01, nvm_size, 0);
        xf(0, 16'h4013, 8'h00, 32'h0000_0001, 0);
        xf(0, 16'h4013, 8'h01, 32'h0000_0000, 0);
        xf(0, 16'h5000, 8'h00, 32'h0000_0000, 1);
        c = $urandom;
        xf(1, 16'h4013, 8'h01, 32'(c), 0);
        xf(0, 16'h4013, 8'h01, 32'(c), 0);
        $display("TB: dictionary test done");
        foreach (codes[n])
        begin
            c = codes[n];
            ramp = (c == 1 || c == 5) ? 2'h1 : (c == 2 || c == 6) ? 2'h2 : 2'h0;
            xf(1, 16'h3701, 8'h00, 32'(c), 0);
            xf(0, 16'h3701, 8'h00, 32'(c), 0);
            pulse(0);
            chk({status_warning_q, power_off_q, ramp_sel_q, drive_state_q}, {1'b1, c == 0, ramp, 2'(c == 0)});
            if (c != 0 && ramp == 2'h0)
            begin
                chk(limit_pos_valid_q, c != -2);
                chk(limit_pos_q, c == -2 ? 32'h0000_0000 : axis_position);
            end
            if (ramp != 2'h0)
            begin
                repeat ($urandom_range(3)) @(posedge clk_sys);
                chk(ramp_sel_q, ramp);
                pulse(1);
                chk({power_off_q, ramp_sel_q, drive_state_q}, {c < 5, 2'h0, c < 5 ? 2'h1 : 2'h2});
            end
            if (c == 0 || ramp != 2'h0)
            begin
                pulse(2);
                chk({status_warning_q, power_off_q, drive_state_q}, 0);
            end
        end
        $display("TB: reaction test done");
        // Mid-run reset must clear the warning and return the stored entries to their reset values
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        chk({status_warning_q, power_off_q, ramp_sel_q, drive_state_q, limit_pos_valid_q}, 0);
        chk(limit_pos_q, 32'h0000_0000);
        xf(0, 16'h3701, 8'h00, 32'hffff_ffff, 0);
        xf(0, 16'h4013, 8'h01, 32'h0000_0000, 0);
        $display("TB: reset test done");
        test_done();
    end
endmodule // lsfr_top_tb
